// ---- hw/port_chip_select_decoder.sv ----
// four port pins, each general-purpose I/O or an address-decoded chip-select strobe
//
// Notes on behaviour
// - Mode code 00 leaves the pin as plain general-purpose I/O with no strobe.
// - Mode code 01 makes the pin a strobe for external reads inside the window.
// - Mode code 10 makes the pin a strobe for external writes inside the window.
// - Mode code 11 makes the pin a strobe for both reads and writes inside the window.
// - The window comes from the pin's base high byte, base low byte and width code.
// - Width code 00 matches only when all 16 address bits equal the base.
// - Width code 01 compares bits 15 to 1 and ignores bit 0.
// - Width code 10 compares bits 15 to 2 and ignores bits 1 and 0.
// - Width code 11 compares bits 15 to 8 and ignores the low byte.
// - Control register 93h holds the fourth pin's fields high and the third's low.
// - The first pin's base sits at 94h (low byte) and 95h (high byte).
// - The second pin's base sits at 96h (low byte) and 97h (high byte).
// - Control register 92h holds the second pin's fields high and the first's low.
// - The third and fourth pins' bases sit at 9Ah/9Bh and 9Ch/9Dh.
// - A polarity bit of 1 gives an active-high strobe, 0 an active-low one.
`timescale 1ns/10ps
module port_chip_select_decoder
  import cs_decoder_pkg::*;
#(
  parameter int N_PINS = NUM_CS
)
(
  input wire logic pclk, // core clock, 100 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 is write
  input wire logic [PADDR_W-1:0] paddr, // apb byte address
  input wire logic [WORD_W-1:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte enables
  output logic [WORD_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [ADDR_W-1:0] ext_addr, // external bus address, core clock domain
  input wire logic ext_rd_n, // external read strobe, active low
  input wire logic ext_wr_n, // external write strobe, active low
  input wire logic [N_PINS-1:0] cs_pin_in, // pin level from the pad
  output logic [N_PINS-1:0] cs_pin_out, // pin drive value
  output logic [N_PINS-1:0] cs_pin_oe // pin output enable, high drives
);

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [BYTE_W-1:0] pin_group_ctrl_a;
  logic [BYTE_W-1:0] pin_group_ctrl_b;
  logic [BYTE_W-1:0] cs_base_low [N_PINS];
  logic [BYTE_W-1:0] cs_base_high [N_PINS];
  logic [NIBBLE_W-1:0] cs_polarity;
  logic [N_PINS-1:0] gpio_out;
  logic [N_PINS-1:0] gpio_dir;

  logic [BYTE_W-1:0] next_pin_group_ctrl_a;
  logic [BYTE_W-1:0] next_pin_group_ctrl_b;
  logic [BYTE_W-1:0] next_cs_base_low [N_PINS];
  logic [BYTE_W-1:0] next_cs_base_high [N_PINS];
  logic [NIBBLE_W-1:0] next_cs_polarity;
  logic [N_PINS-1:0] next_gpio_out;
  logic [N_PINS-1:0] next_gpio_dir;

  logic [IDX_W-1:0] reg_idx;
  logic aligned;
  logic wr_take;
  logic [BYTE_W-1:0] wbyte;
  logic pslverr_next_hold;

  // byte address is index times four; the two low bits must be zero
  assign reg_idx = paddr[WORD_LSB +: IDX_W];
  assign aligned = (paddr[WORD_LSB-1:0] == '0) && (paddr[PADDR_W-1:WORD_LSB+IDX_W] == '0);
  // a write lands only at the edge where the access phase sees pready high
  assign wr_take = psel & penable & pwrite & pready & ~pslverr_next_hold;
  assign wbyte = pwdata[BYTE_W-1:0];

  // a refused access answers with pslverr in the same cycle as pready
  assign pslverr_next_hold = pslverr;

  always_comb
  begin
    next_pin_group_ctrl_a = pin_group_ctrl_a;
    next_pin_group_ctrl_b = pin_group_ctrl_b;
    next_cs_polarity = cs_polarity;
    next_gpio_out = gpio_out;
    next_gpio_dir = gpio_dir;
    for (int i = 0; i < N_PINS; i++)
    begin
      next_cs_base_low[i] = cs_base_low[i];
      next_cs_base_high[i] = cs_base_high[i];
    end
    // only the low byte lane carries register data
    if (wr_take && pstrb[0])
    begin
      if (reg_idx == IDX_CTRL_A)
      begin
        next_pin_group_ctrl_a = wbyte;
      end
      if (reg_idx == IDX_CTRL_B)
      begin
        next_pin_group_ctrl_b = wbyte;
      end
      if (reg_idx == IDX_POLARITY)
      begin
        next_cs_polarity = wbyte[POL_LSB +: NIBBLE_W];
      end
      if (reg_idx == IDX_GPIO_OUT)
      begin
        next_gpio_out = wbyte[N_PINS-1:0];
      end
      if (reg_idx == IDX_GPIO_DIR)
      begin
        next_gpio_dir = wbyte[N_PINS-1:0];
      end
      for (int i = 0; i < N_PINS; i++)
      begin
        if (reg_idx == IDX_BASE_LOW[i])
        begin
          next_cs_base_low[i] = wbyte;
        end
        if (reg_idx == IDX_BASE_HIGH[i])
        begin
          next_cs_base_high[i] = wbyte;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_group_ctrl_a <= RST_BYTE;
      pin_group_ctrl_b <= RST_BYTE;
      cs_polarity <= RST_NIBBLE;
      gpio_out <= '0;
      gpio_dir <= '0;
      for (int i = 0; i < N_PINS; i++)
      begin
        cs_base_low[i] <= RST_BYTE;
        cs_base_high[i] <= RST_BYTE;
      end
    end
    else
    begin
      pin_group_ctrl_a <= next_pin_group_ctrl_a;
      pin_group_ctrl_b <= next_pin_group_ctrl_b;
      cs_polarity <= next_cs_polarity;
      gpio_out <= next_gpio_out;
      gpio_dir <= next_gpio_dir;
      for (int i = 0; i < N_PINS; i++)
      begin
        cs_base_low[i] <= next_cs_base_low[i];
        cs_base_high[i] <= next_cs_base_high[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin field extraction and window match

  logic [NIBBLE_W-1:0] pin_nibble [N_PINS];
  logic [1:0] pin_mode [N_PINS];
  logic [1:0] pin_cmp [N_PINS];
  logic [N_PINS-1:0] pin_hit;
  logic rd_active;
  logic wr_active;

  assign rd_active = ~ext_rd_n;
  assign wr_active = ~ext_wr_n;

  // pins 0 and 1 live in control a, pins 2 and 3 in control b, low nibble first
  assign pin_nibble[0] = pin_group_ctrl_a[0 +: NIBBLE_W];
  assign pin_nibble[1] = pin_group_ctrl_a[NIBBLE_W +: NIBBLE_W];
  assign pin_nibble[2] = pin_group_ctrl_b[0 +: NIBBLE_W];
  assign pin_nibble[3] = pin_group_ctrl_b[NIBBLE_W +: NIBBLE_W];

  genvar g;
  generate
    for (g = 0; g < N_PINS; g++)
    begin : g_pin
      assign pin_mode[g] = {pin_nibble[g][FLD_MODE_HI], pin_nibble[g][FLD_MODE_LO]};
      assign pin_cmp[g] = {pin_nibble[g][FLD_CMP_HI], pin_nibble[g][FLD_CMP_LO]};

      cs_match_unit u_match (
        .bus_addr (ext_addr),
        .base_addr ({cs_base_high[g], cs_base_low[g]}),
        .cmp_width (pin_cmp[g]),
        .mode (pin_mode[g]),
        .rd_active (rd_active),
        .wr_active (wr_active),
        .hit (pin_hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // pin drive; costs one cycle of lag behind the bus strobes so the pads see clean flops

  logic [N_PINS-1:0] cs_state;
  logic [N_PINS-1:0] next_cs_state;
  logic [N_PINS-1:0] next_cs_pin_out;
  logic [N_PINS-1:0] next_cs_pin_oe;

  always_comb
  begin
    for (int i = 0; i < N_PINS; i++)
    begin
      // strobe held for exactly as long as the qualified bus strobe, with no stretch added
      next_cs_state[i] = pin_hit[i];
      if (pin_mode[i] == MODE_GPIO)
      begin
        next_cs_pin_out[i] = gpio_out[i];
        next_cs_pin_oe[i] = gpio_dir[i];
      end
      else
      begin
        // polarity 1 drives the hit level, 0 drives its inverse
        next_cs_pin_out[i] = cs_polarity[i] ? pin_hit[i] : ~pin_hit[i];
        next_cs_pin_oe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_state <= '0;
      cs_pin_out <= '0;
      cs_pin_oe <= '0;
    end
    else
    begin
      cs_state <= next_cs_state;
      cs_pin_out <= next_cs_pin_out;
      cs_pin_oe <= next_cs_pin_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pad level synchroniser; the first stage feeds only the second

  logic [N_PINS-1:0] pin_sync_a;
  logic [N_PINS-1:0] pin_level;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync_a <= '0;
      pin_level <= '0;
    end
    else
    begin
      pin_sync_a <= cs_pin_in;
      pin_level <= pin_sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb response: one wait state, data and error registered with pready

  logic [WORD_W-1:0] rd_mux;
  logic mapped;
  logic next_pready;
  logic next_pslverr;
  logic [WORD_W-1:0] next_prdata;

  always_comb
  begin
    rd_mux = RST_WORD;
    mapped = 1'b0;
    unique case (reg_idx)
      IDX_CTRL_A:
      begin
        rd_mux[BYTE_W-1:0] = pin_group_ctrl_a;
        mapped = 1'b1;
      end
      IDX_CTRL_B:
      begin
        rd_mux[BYTE_W-1:0] = pin_group_ctrl_b;
        mapped = 1'b1;
      end
      IDX_POLARITY:
      begin
        rd_mux[POL_LSB +: NIBBLE_W] = cs_polarity;
        mapped = 1'b1;
      end
      IDX_GPIO_OUT:
      begin
        rd_mux[N_PINS-1:0] = gpio_out;
        mapped = 1'b1;
      end
      IDX_GPIO_DIR:
      begin
        rd_mux[N_PINS-1:0] = gpio_dir;
        mapped = 1'b1;
      end
      IDX_PIN_LEVEL:
      begin
        rd_mux[N_PINS-1:0] = pin_level;
        mapped = 1'b1;
      end
      IDX_CS_STATE:
      begin
        rd_mux[N_PINS-1:0] = cs_state;
        mapped = 1'b1;
      end
      default:
      begin
        for (int i = 0; i < N_PINS; i++)
        begin
          if (reg_idx == IDX_BASE_LOW[i])
          begin
            rd_mux[BYTE_W-1:0] = cs_base_low[i];
            mapped = 1'b1;
          end
          if (reg_idx == IDX_BASE_HIGH[i])
          begin
            rd_mux[BYTE_W-1:0] = cs_base_high[i];
            mapped = 1'b1;
          end
        end
      end
    endcase
    // read-only status words refuse writes
    if (pwrite && (reg_idx == IDX_PIN_LEVEL || reg_idx == IDX_CS_STATE))
    begin
      mapped = 1'b0;
    end
    if (!aligned)
    begin
      mapped = 1'b0;
    end
  end

  always_comb
  begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = RST_WORD;
    if (psel && penable && !pready)
    begin
      next_pready = 1'b1;
      next_pslverr = ~mapped;
      if (!pwrite && mapped)
      begin
        next_prdata = rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RST_WORD;
    end
    else
    begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

endmodule

// ---- shared/cs_decoder_pkg.sv ----
// constants, register map and field layout of the port chip-select decoder
package cs_decoder_pkg;

  localparam int NUM_CS = 4;
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int IDX_W = 8;
  localparam int PADDR_W = 12;
  localparam int WORD_W = 32;
  localparam int WORD_LSB = 2;

  // alternate-mode codes of a pin
  localparam logic [1:0] MODE_GPIO = 2'b00;
  localparam logic [1:0] MODE_RD = 2'b01;
  localparam logic [1:0] MODE_WR = 2'b10;
  localparam logic [1:0] MODE_RW = 2'b11;

  // compare-width codes and the address bits each one keeps
  localparam logic [1:0] CMP_FULL = 2'b00;
  localparam logic [1:0] CMP_A1 = 2'b01;
  localparam logic [1:0] CMP_A2 = 2'b10;
  localparam logic [1:0] CMP_A8 = 2'b11;
  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [15:0] MASK_A1 = 16'hfffe;
  localparam logic [15:0] MASK_A2 = 16'hfffc;
  localparam logic [15:0] MASK_A8 = 16'hff00;

  // layout of one nibble of a pin group control register
  localparam int FLD_MODE_HI = 3;
  localparam int FLD_MODE_LO = 2;
  localparam int FLD_CMP_HI = 1;
  localparam int FLD_CMP_LO = 0;
  localparam int POL_LSB = 4;

  // register indices; byte address on the bus is index times four
  localparam logic [7:0] IDX_CTRL_A = 8'h92;
  localparam logic [7:0] IDX_CTRL_B = 8'h93;
  localparam logic [7:0] IDX_POLARITY = 8'ha2;
  localparam logic [7:0] IDX_GPIO_OUT = 8'ha8;
  localparam logic [7:0] IDX_GPIO_DIR = 8'ha9;
  localparam logic [7:0] IDX_PIN_LEVEL = 8'haa;
  localparam logic [7:0] IDX_CS_STATE = 8'hab;
  localparam logic [7:0] IDX_BASE_LOW [NUM_CS] = '{8'h94, 8'h96, 8'h9a, 8'h9c};
  localparam logic [7:0] IDX_BASE_HIGH [NUM_CS] = '{8'h95, 8'h97, 8'h9b, 8'h9d};

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage

// ---- hw/cs_match_unit.sv ----
// address window compare and access-type qualify for one chip-select pin
`timescale 1ns/10ps
module cs_match_unit
  import cs_decoder_pkg::*;
(
  input wire logic [ADDR_W-1:0] bus_addr, // external bus address
  input wire logic [ADDR_W-1:0] base_addr, // programmed base address
  input wire logic [1:0] cmp_width, // compare-width code
  input wire logic [1:0] mode, // alternate-mode code
  input wire logic rd_active, // external read strobe active
  input wire logic wr_active, // external write strobe active
  output logic hit // strobe should be active
);

  logic [ADDR_W-1:0] keep_mask;
  logic addr_match;
  logic type_ok;

  always_comb
  begin
    unique case (cmp_width)
      CMP_FULL: keep_mask = MASK_FULL;
      CMP_A1: keep_mask = MASK_A1;
      CMP_A2: keep_mask = MASK_A2;
      CMP_A8: keep_mask = MASK_A8;
    endcase
  end

  assign addr_match = ((bus_addr ^ base_addr) & keep_mask) == '0;

  always_comb
  begin
    unique case (mode)
      MODE_GPIO: type_ok = 1'b0;
      MODE_RD: type_ok = rd_active;
      MODE_WR: type_ok = wr_active;
      MODE_RW: type_ok = rd_active | wr_active;
    endcase
  end

  assign hit = addr_match & type_ok;

endmodule

// ---- verification/port_chip_select_decoder_properties.sv ----
// port timing checks of the chip-select decoder
`timescale 1ns/10ps
module port_chip_select_decoder_properties
  import cs_decoder_pkg::*;
#(
  parameter int N_PINS = NUM_CS
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [WORD_W-1:0] prdata, // read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic ext_rd_n, // read strobe
  input wire logic ext_wr_n, // write strobe
  input wire logic [N_PINS-1:0] cs_pin_out, // pin drive
  input wire logic [N_PINS-1:0] cs_pin_oe // pin enable
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic quiet;
  logic wr_done;
  assign quiet = ext_rd_n && ext_wr_n;
  assign wr_done = psel && penable && pready && pwrite;
  ////////////////////////////////////////
  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer missed its wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  chk_rdata_quiet: assert property (!pready || pslverr |-> prdata == '0)
    else $error("read data not zero");
  chk_pin_hold: assert property ((quiet && !wr_done) [*3] |=> $stable(cs_pin_out))
    else $error("pin moved without strobe");
  chk_oe_hold: assert property ((!wr_done) [*3] |=> $stable(cs_pin_oe))
    else $error("pin enable moved without write");
  // a drive change must trace back to a strobe or a write within two edges
  chk_pin_cause: assert property ($changed(cs_pin_out) && !$past(wr_done) &&
    !$past(wr_done, 2) |-> !$past(quiet) || !$past(quiet, 2))
    else $error("pin change without cause");
endmodule
bind port_chip_select_decoder port_chip_select_decoder_properties #(.N_PINS(N_PINS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_rd_n(ext_rd_n),
  .ext_wr_n(ext_wr_n), .cs_pin_out(cs_pin_out), .cs_pin_oe(cs_pin_oe)
);

// ---- verification/cs_target_model.sv ----
// external target selected by one chip-select strobe
`timescale 1ns/10ps
module cs_target_model #(
  parameter logic active_high = 1'b1
)
(
  input wire logic pclk, // clock
  input wire logic cs_level, // strobe pad level
  input wire logic [7:0] store, // byte returned when selected
  output logic [7:0] data, // target data bus
  output logic [7:0] hits // selected cycles seen
);
  logic sel;
  assign sel = cs_level == active_high;
  // released bus shows the inverse of the stored byte so no stale byte passes
  assign data = sel ? store : ~store;
  initial
  begin
    hits = 8'h00;
  end
  always @(posedge pclk)
  begin
    if (sel)
      hits <= hits + 8'h01;
  end
endmodule

// ---- verification/port_chip_select_decoder_tb_top.sv ----
// self-checking bench of the port chip-select decoder
`timescale 1ns/10ps
module port_chip_select_decoder_tb_top;
  import cs_decoder_pkg::*;
  // m mode, c width code, a bus address, act strobe expected
  typedef struct packed {logic [1:0] m; logic [1:0] c; logic [15:0] a;
    logic rdn; logic wrn; logic act;} row_t;
  localparam row_t rows [11] = '{
    '{2'h1, 2'h0, 16'h1234, 1'h0, 1'h1, 1'h1}, '{2'h1, 2'h0, 16'h1235, 1'h0, 1'h1, 1'h0},
    '{2'h1, 2'h0, 16'h1234, 1'h1, 1'h0, 1'h0}, '{2'h2, 2'h1, 16'h1235, 1'h1, 1'h0, 1'h1},
    '{2'h2, 2'h1, 16'h1236, 1'h1, 1'h0, 1'h0}, '{2'h2, 2'h1, 16'h1234, 1'h0, 1'h1, 1'h0},
    '{2'h3, 2'h2, 16'h1237, 1'h0, 1'h1, 1'h1}, '{2'h3, 2'h2, 16'h1238, 1'h1, 1'h0, 1'h0},
    '{2'h3, 2'h3, 16'h12ff, 1'h1, 1'h0, 1'h1}, '{2'h3, 2'h3, 16'h1334, 1'h0, 1'h1, 1'h0},
    '{2'h0, 2'h3, 16'h1234, 1'h0, 1'h1, 1'h0}};
  localparam logic [7:0] regs [13] = '{8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
    8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'ha2, 8'ha8, 8'ha9};
  localparam logic [7:0] rmask [13] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'h0f, 8'h0f};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_rd_n, ext_wr_n, err;
  logic [PADDR_W-1:0] paddr;
  logic [WORD_W-1:0] pwdata, prdata, rd;
  logic [3:0] cs_pin_in, cs_pin_out, cs_pin_oe;
  logic [ADDR_W-1:0] ext_addr;
  logic [7:0] t_data, t_hits, h0;
  int errors, total_checks, cycles;
  // undriven pads float high through the board pull-up
  assign cs_pin_in = cs_pin_out | ~cs_pin_oe;
  port_chip_select_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_addr(ext_addr),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .cs_pin_in(cs_pin_in),
    .cs_pin_out(cs_pin_out), .cs_pin_oe(cs_pin_oe));
  cs_target_model #(.active_high(1'b1)) u_target (.pclk(pclk), .cs_level(cs_pin_in[0]),
    .store(8'hc3), .data(t_data), .hits(t_hits));
  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 12'({idx, 2'b00});
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      print_verdict;
    end
  end
  ////////////////////////////////////////
  initial
  begin
    int p;
    logic pol;
    row_t r;
    {presetn, psel, penable, pwrite, errors, total_checks, cycles} = '0;
    {paddr, pwdata, ext_addr} = '0;
    {ext_rd_n, ext_wr_n} = 2'b11;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 13; k++)
    begin
      apb(1'b0, regs[k], 32'h0);
      cmp({err, rd[30:0]}, 32'h0);
    end
    for (int k = 0; k < 13; k++)
      apb(1'b1, regs[k], 32'h11 * (k + 1));
    for (int k = 0; k < 13; k++)
    begin
      apb(1'b0, regs[k], 32'h0);
      cmp({err, rd[30:0]}, (32'h11 * (k + 1)) & 32'(rmask[k]));
    end
    apb(1'b1, 8'hab, 32'hff);
    cmp({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 8'h98, 32'h0);
    cmp({err, rd[30:0]}, 32'h8000_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    cmp(32'({cs_pin_oe, cs_pin_out}), 32'h0);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      r = rows[i];
      p = i % 4;
      pol = i[2];
      apb(1'b1, 8'ha2, 32'(pol) << (4 + p));
      apb(1'b1, regs[p / 2], 32'({r.m, r.c}) << (4 * (p % 2)));
      apb(1'b1, regs[2 + 2 * p], 32'h34);
      apb(1'b1, regs[3 + 2 * p], 32'h12);
      @(posedge pclk);
      ext_addr <= r.a;
      ext_rd_n <= r.rdn;
      ext_wr_n <= r.wrn;
      settle;
      cmp(32'({cs_pin_oe[p], cs_pin_out[p]}), 32'({r.m != 2'h0, (r.m != 2'h0) && (r.act == pol)}));
      @(posedge pclk);
      ext_rd_n <= 1'b1;
      ext_wr_n <= 1'b1;
      settle;
      cmp(32'({cs_pin_oe[p], cs_pin_out[p]}), 32'({r.m != 2'h0, (r.m != 2'h0) && !pol}));
    end
    apb(1'b1, 8'ha2, 32'h10);
    apb(1'b1, 8'h92, 32'h07);
    repeat (3) @(posedge pclk);
    h0 = t_hits;
    ext_addr <= 16'h12ab;
    ext_rd_n <= 1'b0;
    settle;
    cmp(32'(t_data), 32'hc3);
    repeat (3) @(posedge pclk);
    ext_rd_n <= 1'b1;
    settle;
    cmp(32'(8'(t_hits - h0)), 32'h5);
    cmp(32'(t_data == 8'hc3), 32'h0);
    apb(1'b1, 8'ha8, 32'h0a);
    apb(1'b1, 8'ha9, 32'h0e);
    settle;
    cmp(32'({cs_pin_oe, cs_pin_out}), 32'hfa);
    apb(1'b0, 8'haa, 32'h0);
    cmp({err, rd[30:0]}, 32'h0a);
    @(posedge pclk);
    ext_rd_n <= 1'b0;
    apb(1'b0, 8'hab, 32'h0);
    cmp({err, rd[30:0]}, 32'h01);
    @(posedge pclk);
    ext_rd_n <= 1'b1;
    print_verdict;
  end
endmodule
